// >>> ccs_pkg.sv
// constants, field layouts and carrier types for the charger control/status register bank
// assumes a 50 MHz system clock; every other file imports this package whole
package ccs_pkg;

    // clock rate and derived timing
    localparam int unsigned CLK_HZ = 50_000_000;
    localparam int unsigned BATSW_OFF_DELAY_S = 10;
    localparam int unsigned BATSW_OFF_DELAY_CYCLES = BATSW_OFF_DELAY_S * CLK_HZ;

    // target address on the serial bus; value is arbitrary
    localparam logic [6:0] DEV_ADDR_DEFAULT = 7'h2A;

    // register offsets
    localparam logic [7:0] ADDR_MISC_CTRL = 8'h07;
    localparam logic [7:0] ADDR_OP_STATUS = 8'h08;
    localparam logic [7:0] ADDR_FAULT_STATUS = 8'h09;
    localparam logic [7:0] ADDR_SYS_CTRL = 8'h0B;
    localparam int unsigned SYS_CTRL_REG_RESET_BIT = 7;

    // control reset value and the fields that survive a watchdog expiry
    localparam logic [7:0] MISC_CTRL_RST = 8'h4C;
    localparam logic [7:0] MISC_CTRL_WD_KEEP = 8'h2B;

    // input source codes
    localparam logic [2:0] SRC_NONE = 3'h0;
    localparam logic [2:0] SRC_SDP = 3'h1;
    localparam logic [2:0] SRC_ADAPTER = 3'h3;
    localparam logic [2:0] SRC_OTG = 3'h7;

    // charge fault codes
    localparam logic [1:0] CFLT_NORMAL = 2'h0;
    localparam logic [1:0] CFLT_INPUT = 2'h1;
    localparam logic [1:0] CFLT_THERMAL = 2'h2;
    localparam logic [1:0] CFLT_TIMER = 2'h3;

    // thermistor codes
    localparam logic [2:0] NTC_NORMAL = 3'h0;
    localparam logic [2:0] NTC_COLD = 3'h5;
    localparam logic [2:0] NTC_HOT = 3'h6;

    // input voltage limit arithmetic, millivolts
    localparam logic [13:0] IVL_BASE_MV = 14'h0F3C;
    localparam logic [13:0] IVL_STEP_MV = 14'h0064;
    localparam logic [13:0] TRACK_200_MV = 14'h00C8;
    localparam logic [13:0] TRACK_250_MV = 14'h00FA;
    localparam logic [13:0] TRACK_300_MV = 14'h012C;

    // control register layout, bit 7 first
    typedef struct packed {
        logic force_source_detect;
        logic timer_halfrate_enable;
        logic battery_switch_disable;
        logic warm_charge_voltage_select;
        logic battery_switch_off_delay;
        logic battery_switch_reset_enable;
        logic [1:0] input_limit_track_offset;
    } ccs_misc_ctrl_t;

    // live conditions from the charger core, same clock domain
    typedef struct packed {
        logic input_present;
        logic otg_mode;
        logic [2:0] detect_code;
        logic [1:0] charge_phase;
        logic power_good;
        logic thermal_reg;
        logic min_system_reg;
        logic watchdog_expired;
        logic boost_overload;
        logic input_overvoltage;
        logic battery_low;
        logic input_undervoltage;
        logic thermal_shutdown;
        logic safety_expired;
        logic battery_overvoltage;
        logic boost_mode;
        logic [2:0] thermistor;
        logic warm_band;
        logic input_dpm;
        logic jeita_cool;
    } ccs_live_t;

    // serial target states
    typedef enum logic [3:0] {
        ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_REG, ST_REG_ACK, ST_WR, ST_WR_ACK, ST_RD, ST_RD_ACK
    } ccs_state_t;

endpackage : ccs_pkg

// >>> ccs_sync2.sv
// two-flop synchroniser for pin levels entering the system clock domain
// assumes the inputs are slow levels; first stage feeds only the second
`timescale 1ns/100ps
module ccs_sync2 import ccs_pkg::*; #(
    parameter int unsigned W = 1
) (
    input wire logic sys_clk_i,
    input wire logic rst_i,
    input wire logic [W-1:0] async_i,
    output logic [W-1:0] sync_o
);
    logic [W-1:0] meta_r;

    generate
        if (W < 1) begin : g_bad_width
            $error("ccs_sync2 width must be at least one");
        end
    endgenerate

    // two stages, reset high like the pulled-up idle pins, so no false edge follows reset
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            meta_r <= '1;
            sync_o <= '1;
        end else begin
            meta_r <= async_i;
            sync_o <= meta_r;
        end
    end

endmodule : ccs_sync2

// >>> ccs_off_delay.sv
// battery switch gate control with optional turn-off delay
// assumes disable and delay select come from the control register, same clock
`timescale 1ns/100ps
module ccs_off_delay import ccs_pkg::*; #(
    parameter int unsigned DELAY_CYCLES = BATSW_OFF_DELAY_CYCLES
) (
    input wire logic sys_clk_i,
    input wire logic rst_i,
    input wire logic disable_i,
    input wire logic delay_sel_i,
    output logic switch_on_o
);
    localparam int unsigned CW = $clog2(DELAY_CYCLES + 1);
    localparam logic [CW-1:0] LAST = CW'(DELAY_CYCLES - 1);
    logic [CW-1:0] cnt_r;

    generate
        if (DELAY_CYCLES < 1) begin : g_bad_delay
            $error("ccs_off_delay needs at least one cycle of delay");
        end
    endgenerate

    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (rst_i);

    // delay counter runs only while a delayed turn-off is pending
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            cnt_r <= '0;
        end else if (!disable_i || !delay_sel_i) begin
            cnt_r <= '0;
        end else if (cnt_r != LAST) begin
            cnt_r <= cnt_r + 1'b1;
        end
    end

    // switch gate: on when allowed, off at once or after the delay
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            switch_on_o <= 1'b1;
        end else if (!disable_i) begin
            switch_on_o <= 1'b1;
        end else if (!delay_sel_i || cnt_r == LAST) begin
            switch_on_o <= 1'b0;
        end
    end

    chk_switch_allowed_on: assert property (!disable_i |=> switch_on_o)
        else $error("battery switch not on while allowed");
    chk_switch_off_now: assert property (disable_i && !delay_sel_i |=> !switch_on_o)
        else $error("battery switch not off at once");
    chk_switch_delayed: assert property (
        $rose(disable_i) && delay_sel_i && $past(switch_on_o) |=> switch_on_o)
        else $error("battery switch went off without delay");

endmodule : ccs_off_delay

// >>> ccs_regs.sv
// charger control/status register bank behind a serial two-wire target
// assumes scl/sda and the select pin come from pins; live status comes from logic on sys_clk_i
// Summary of operation
// - detection-force bit resets 0; writing 1 forces source detection.
// - select-pin variant reads detection-force bit as the select pin level.
// - timer half-rate bit (reset 1) halves safety timer during limiting, cool or thermal.
// - switch-disable bit resets 0 allowing switch on; 1 turns it off.
// - delay bit resets 1; 0 turns switch off at once, 1 after ten seconds.
// - warm-band voltage bit 0 caps charge at 4.1V; 1 uses programmed setting.
// - switch reset enable bit resets 1; 0 disables, 1 enables the reset function.
// - applied input limit is register threshold, or with nonzero offset the larger of it and battery plus offset.
// - detection variant reports none, source code from the detector as given, OTG.
// - select-pin variant reports none, SDP for pin high, adapter for low, OTG.
// - charge phase status reports not charging, precharge, fast charge, terminated.
// - thermal bit reads 1 while in thermal regulation.
// - watchdog fault bit reads 1 after the watchdog expired.
// - boost fault reads 1 on overload, input overvoltage or low battery.
// - charge fault code: normal, input fault, thermal shutdown, safety timer.
// - battery fault bit reads 1 on battery overvoltage.
// - buck mode thermistor codes: normal, warm, cool, cold, hot.
// - boost mode thermistor reports only normal, cold or hot.
// - register-reset bit restores defaults, restarts safety timer, then reads 0.
`timescale 1ns/100ps
module ccs_regs import ccs_pkg::*; #(
    parameter bit USE_SELECT_PIN = 1'b0,
    parameter logic [6:0] DEV_ADDR = DEV_ADDR_DEFAULT,
    parameter int unsigned OFF_DELAY_CYCLES = BATSW_OFF_DELAY_CYCLES
) (
    input wire logic sys_clk_i,
    input wire logic rst_i,
    input wire logic scl_i,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe_o,
    input wire logic select_pin_i,
    input wire ccs_live_t live_i,
    input wire logic [3:0] input_voltage_limit_i,
    input wire logic [12:0] battery_mv_i,
    input wire logic safety_tick_i,
    output logic safety_tick_o,
    output logic safety_timer_restart_o,
    output logic force_source_detect_o,
    output logic battery_switch_on_o,
    output logic battery_switch_reset_enable_o,
    output logic warm_voltage_cap_o,
    output logic [13:0] input_voltage_limit_mv_o
);
    ccs_state_t state_r;
    ccs_misc_ctrl_t ctrl_r;
    logic [7:0] op_status_r;
    logic [7:0] fault_status_r;
    logic [2:0] pins_s;
    logic scl_s, sda_s, sel_s, scl_d_r, sda_d_r;
    logic scl_rise, scl_fall, bus_start, bus_stop;
    logic [3:0] bit_cnt_r;
    logic [7:0] shift_r, tx_r, ptr_r;
    logic rw_r, drive_low_r, master_ack_r;
    logic wr_en, reg_rst_pulse, wd_pulse, wd_d_r, slow, half_phase_r;
    logic [13:0] reg_thr_mv, track_mv, track_add;
    logic [2:0] src_code, ntc_code;
    logic [1:0] cflt_code;

    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (rst_i);

    // pin synchronisers for clock, data and select pin
    ccs_sync2 #(.W(3)) u_sync (
        .sys_clk_i(sys_clk_i),
        .rst_i(rst_i),
        .async_i({scl_i, sda_i, select_pin_i}),
        .sync_o(pins_s)
    );
    assign {scl_s, sda_s, sel_s} = pins_s;

    // bus edge and condition detection on synchronised levels
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            scl_d_r <= 1'b1;
            sda_d_r <= 1'b1;
        end else begin
            scl_d_r <= scl_s;
            sda_d_r <= sda_s;
        end
    end
    assign scl_rise = scl_s && !scl_d_r;
    assign scl_fall = !scl_s && scl_d_r;
    assign bus_start = scl_s && scl_d_r && sda_d_r && !sda_s;
    assign bus_stop = scl_s && scl_d_r && !sda_d_r && sda_s;

    // open-drain data: only ever pulls low
    assign sda_o = 1'b0;
    assign sda_oe_o = drive_low_r;

    // read data for a register pointer
    function automatic logic [7:0] read_mux(input logic [7:0] ptr);
        logic [7:0] misc;
        misc = ctrl_r;
        if (USE_SELECT_PIN) begin
            misc[7] = sel_s;
        end
        unique case (ptr)
            ADDR_MISC_CTRL: read_mux = misc;
            ADDR_OP_STATUS: read_mux = op_status_r;
            ADDR_FAULT_STATUS: read_mux = fault_status_r;
            default: read_mux = 8'h00; // register-reset bit reads 0 once done
        endcase
    endfunction : read_mux

    // serial target: address, pointer, write bytes, read bytes
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            state_r <= ST_IDLE;
            bit_cnt_r <= 4'h0;
            shift_r <= 8'h00;
            tx_r <= 8'h00;
            ptr_r <= 8'h00;
            rw_r <= 1'b0;
            drive_low_r <= 1'b0;
            master_ack_r <= 1'b0;
        end else if (bus_stop) begin
            state_r <= ST_IDLE;
            drive_low_r <= 1'b0;
        end else if (bus_start) begin
            state_r <= ST_ADDR;
            bit_cnt_r <= 4'h0;
            drive_low_r <= 1'b0;
        end else if (scl_rise) begin
            unique case (state_r)
                ST_ADDR, ST_REG, ST_WR: begin
                    shift_r <= {shift_r[6:0], sda_s};
                    bit_cnt_r <= bit_cnt_r + 4'h1;
                end
                ST_RD_ACK: master_ack_r <= !sda_s;
                default: begin
                end
            endcase
        end else if (scl_fall) begin
            unique case (state_r)
                ST_IDLE: begin
                end
                ST_ADDR: begin
                    if (bit_cnt_r == 4'h8) begin
                        if (shift_r[7:1] == DEV_ADDR) begin
                            state_r <= ST_ADDR_ACK;
                            rw_r <= shift_r[0];
                            drive_low_r <= 1'b1;
                        end else begin
                            state_r <= ST_IDLE;
                        end
                    end
                end
                ST_ADDR_ACK: begin
                    bit_cnt_r <= 4'h0;
                    if (rw_r) begin
                        state_r <= ST_RD;
                        tx_r <= read_mux(ptr_r);
                        drive_low_r <= read_mux(ptr_r) < 8'h80; // pull low for a zero msb
                    end else begin
                        state_r <= ST_REG;
                        drive_low_r <= 1'b0;
                    end
                end
                ST_REG: begin
                    if (bit_cnt_r == 4'h8) begin
                        state_r <= ST_REG_ACK;
                        ptr_r <= shift_r;
                        drive_low_r <= 1'b1;
                    end
                end
                ST_WR: begin
                    if (bit_cnt_r == 4'h8) begin
                        state_r <= ST_WR_ACK;
                        drive_low_r <= 1'b1;
                    end
                end
                ST_REG_ACK, ST_WR_ACK: begin
                    if (state_r == ST_WR_ACK) begin
                        ptr_r <= ptr_r + 8'h01;
                    end
                    state_r <= ST_WR;
                    bit_cnt_r <= 4'h0;
                    drive_low_r <= 1'b0;
                end
                ST_RD: begin
                    if (bit_cnt_r == 4'h7) begin
                        state_r <= ST_RD_ACK;
                        ptr_r <= ptr_r + 8'h01;
                        drive_low_r <= 1'b0;
                    end else begin
                        tx_r <= {tx_r[6:0], 1'b0};
                        drive_low_r <= !tx_r[6];
                        bit_cnt_r <= bit_cnt_r + 4'h1;
                    end
                end
                ST_RD_ACK: begin
                    bit_cnt_r <= 4'h0;
                    if (master_ack_r) begin
                        state_r <= ST_RD;
                        tx_r <= read_mux(ptr_r);
                        drive_low_r <= read_mux(ptr_r) < 8'h80;
                    end else begin
                        state_r <= ST_IDLE;
                    end
                end
            endcase
        end
    end

    // byte write lands as the eighth bit closes; status offsets take no write
    assign wr_en = scl_fall && !bus_stop && !bus_start && state_r == ST_WR
        && bit_cnt_r == 4'h8;
    assign reg_rst_pulse = wr_en && ptr_r == ADDR_SYS_CTRL
        && shift_r[SYS_CTRL_REG_RESET_BIT];
    assign wd_pulse = live_i.watchdog_expired && !wd_d_r;

    // watchdog expiry edge
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            wd_d_r <= 1'b0;
        end else begin
            wd_d_r <= live_i.watchdog_expired;
        end
    end

    // control register: reset, watchdog restore, host write
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            ctrl_r <= MISC_CTRL_RST;
        end else if (reg_rst_pulse) begin
            ctrl_r <= MISC_CTRL_RST;
        end else if (wd_pulse) begin
            ctrl_r <= (ctrl_r & MISC_CTRL_WD_KEEP) | (MISC_CTRL_RST & ~MISC_CTRL_WD_KEEP);
        end else if (wr_en && ptr_r == ADDR_MISC_CTRL) begin
            ctrl_r <= shift_r;
        end
    end

    // safety timer restart strobe
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            safety_timer_restart_o <= 1'b0;
        end else begin
            safety_timer_restart_o <= reg_rst_pulse;
        end
    end

    // status encoding from live conditions
    always_comb begin
        if (live_i.otg_mode) begin
            src_code = SRC_OTG;
        end else if (!live_i.input_present) begin
            src_code = SRC_NONE;
        end else if (USE_SELECT_PIN) begin
            src_code = sel_s ? SRC_SDP : SRC_ADAPTER;
        end else begin
            src_code = live_i.detect_code;
        end
        if (live_i.thermal_shutdown) begin
            cflt_code = CFLT_THERMAL;
        end else if (live_i.input_overvoltage || live_i.input_undervoltage) begin
            cflt_code = CFLT_INPUT;
        end else if (live_i.safety_expired) begin
            cflt_code = CFLT_TIMER;
        end else begin
            cflt_code = CFLT_NORMAL;
        end
        ntc_code = live_i.thermistor;
        if (live_i.boost_mode && live_i.thermistor != NTC_COLD
            && live_i.thermistor != NTC_HOT) begin
            ntc_code = NTC_NORMAL;
        end
    end

    // read-only status registers refreshed every cycle
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            op_status_r <= 8'h00;
            fault_status_r <= 8'h00;
        end else begin
            op_status_r <= {src_code, live_i.charge_phase, live_i.power_good,
                live_i.thermal_reg, live_i.min_system_reg};
            fault_status_r <= {live_i.watchdog_expired,
                live_i.boost_overload || live_i.input_overvoltage || live_i.battery_low,
                cflt_code, live_i.battery_overvoltage, ntc_code};
        end
    end

    // safety timer tick passes every other tick while slowed
    assign slow = ctrl_r.timer_halfrate_enable && (live_i.input_dpm || live_i.jeita_cool
        || live_i.thermal_reg);
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            half_phase_r <= 1'b0;
            safety_tick_o <= 1'b0;
        end else begin
            if (safety_tick_i && slow) begin
                half_phase_r <= !half_phase_r;
            end
            safety_tick_o <= safety_tick_i && (!slow || half_phase_r);
        end
    end

    // input voltage limit with battery tracking
    always_comb begin
        unique case (ctrl_r.input_limit_track_offset)
            2'h1: track_add = TRACK_200_MV;
            2'h2: track_add = TRACK_250_MV;
            2'h3: track_add = TRACK_300_MV;
            default: track_add = 14'h0000;
        endcase
        reg_thr_mv = 14'(IVL_BASE_MV + 14'(IVL_STEP_MV * {10'h000, input_voltage_limit_i}));
        track_mv = 14'({1'b0, battery_mv_i} + track_add);
    end

    // applied limit and plain control outputs
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            input_voltage_limit_mv_o <= IVL_BASE_MV;
            warm_voltage_cap_o <= 1'b0;
        end else begin
            if (ctrl_r.input_limit_track_offset != 2'h0 && track_mv > reg_thr_mv) begin
                input_voltage_limit_mv_o <= track_mv;
            end else begin
                input_voltage_limit_mv_o <= reg_thr_mv;
            end
            warm_voltage_cap_o <= live_i.warm_band && !ctrl_r.warm_charge_voltage_select;
        end
    end
    assign force_source_detect_o = ctrl_r.force_source_detect;
    assign battery_switch_reset_enable_o = ctrl_r.battery_switch_reset_enable;

    // battery switch gate with turn-off delay
    ccs_off_delay #(.DELAY_CYCLES(OFF_DELAY_CYCLES)) u_off_delay (
        .sys_clk_i(sys_clk_i),
        .rst_i(rst_i),
        .disable_i(ctrl_r.battery_switch_disable),
        .delay_sel_i(ctrl_r.battery_switch_off_delay),
        .switch_on_o(battery_switch_on_o)
    );

    chk_reg_reset_defaults: assert property (reg_rst_pulse |=> ctrl_r == MISC_CTRL_RST
        && safety_timer_restart_o) else $error("register reset did not restore defaults");
    chk_wd_keeps_fields: assert property (wd_pulse && !reg_rst_pulse |=>
        (ctrl_r & MISC_CTRL_WD_KEEP) == ($past(ctrl_r) & MISC_CTRL_WD_KEEP)
        && ctrl_r.timer_halfrate_enable && !ctrl_r.force_source_detect)
        else $error("watchdog restore wrong");
    chk_no_track_limit: assert property (ctrl_r.input_limit_track_offset == 2'h0
        ##0 $stable(input_voltage_limit_i) |=> input_voltage_limit_mv_o == $past(reg_thr_mv))
        else $error("untracked limit not register value");
    chk_track_limit_max: assert property (ctrl_r.input_limit_track_offset != 2'h0
        |=> input_voltage_limit_mv_o >= $past(track_mv)
        && input_voltage_limit_mv_o >= $past(reg_thr_mv))
        else $error("tracked limit below a source");
    chk_tick_full_rate: assert property (safety_tick_i && !slow |=> safety_tick_o)
        else $error("tick lost at full rate");
    chk_tick_half_rate: assert property (safety_tick_i && slow && !half_phase_r
        |=> !safety_tick_o ##0 half_phase_r) else $error("slowed tick not halved");
    chk_select_source: assert property (USE_SELECT_PIN && live_i.input_present
        && !live_i.otg_mode |=> op_status_r[7:5] == ($past(sel_s) ? SRC_SDP : SRC_ADAPTER))
        else $error("select pin source code wrong");
    chk_boost_ntc: assert property (live_i.boost_mode |=> fault_status_r[2:0] == NTC_NORMAL
        || fault_status_r[2:0] == NTC_COLD || fault_status_r[2:0] == NTC_HOT)
        else $error("boost thermistor code illegal");
    chk_addr_ack: assert property (scl_fall && !bus_start && !bus_stop && state_r == ST_ADDR
        && bit_cnt_r == 4'h8 && shift_r[7:1] == DEV_ADDR |=> sda_oe_o ##0 state_r == ST_ADDR_ACK)
        else $error("own address not acknowledged");
    chk_warm_cap: assert property (live_i.warm_band && !ctrl_r.warm_charge_voltage_select
        |=> warm_voltage_cap_o) else $error("warm cap not applied");

endmodule : ccs_regs

// >>> ccs_host_model.sv
// serial bus host model: drives the clock and pulls the data wire low
// assumes a pull-up on data, so a released line reads high
`timescale 1ns/100ps
module ccs_host_model import ccs_pkg::*; (
    input wire logic sys_clk_i,
    input wire logic sda_i,
    output logic scl_o,
    output logic sda_low_o
);
    int nak = 0;
    // target address of the next frames; the bench may change it
    logic [6:0] adr = DEV_ADDR_DEFAULT;
    // bus idles with both lines released
    initial begin
        scl_o = 1'b1;
        sda_low_o = 1'b0;
    end
    // eight clocks per phase keeps every high and low time legal
    task automatic hw();
        repeat (8) @(negedge sys_clk_i);
    endtask : hw
    task automatic bit_x(input logic b, output logic r);
        sda_low_o = ~b;
        hw();
        scl_o = 1'b1;
        hw();
        r = sda_i;
        scl_o = 1'b0;
        hw();
    endtask : bit_x
    // start, or repeated start when the clock is low
    task automatic start();
        sda_low_o = 1'b0;
        hw();
        scl_o = 1'b1;
        hw();
        sda_low_o = 1'b1;
        hw();
        scl_o = 1'b0;
        hw();
    endtask : start
    task automatic stop();
        sda_low_o = 1'b1;
        hw();
        scl_o = 1'b1;
        hw();
        sda_low_o = 1'b0;
        hw();
    endtask : stop
    task automatic byte_x(input logic [7:0] d, input logic ackv, output logic [7:0] q);
        logic a;
        for (int i = 7; i >= 0; i--) begin
            bit_x(d[i], q[i]);
        end
        bit_x(ackv, a);
        if (ackv && a !== 1'b0 && d !== 8'hFF) begin
            nak++;
        end
    endtask : byte_x
    task automatic wr(input logic [7:0] r, input logic [7:0] d);
        logic [7:0] q;
        start();
        byte_x({adr, 1'b0}, 1'b1, q);
        byte_x(r, 1'b1, q);
        byte_x(d, 1'b1, q);
        stop();
    endtask : wr
    // pointer write, repeated start, one byte read then not acknowledged
    task automatic rd(input logic [7:0] r, output logic [7:0] d);
        logic [7:0] q;
        start();
        byte_x({adr, 1'b0}, 1'b1, q);
        byte_x(r, 1'b1, q);
        start();
        byte_x({adr, 1'b1}, 1'b1, q);
        byte_x(8'hFF, 1'b1, d);
        stop();
    endtask : rd
endmodule : ccs_host_model

// >>> tb.sv
// testbench for the charger register bank: host model on the pins, live status from here
// assumes the host model is compiled first
`timescale 1ns/100ps
module tb import ccs_pkg::*; ;
    logic sys_clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic scl, sda_low, sda_oe, fsd, bre, on;
    logic tick = 1'b0, sel = 1'b1, tick_out, restart, wc, sdo, sda_oe_b;
    logic [13:0] lim;
    logic [7:0] v;
    int errors = 0;
    int n_tests = 0;
    int n_tick = 0;
    int n_restart = 0;
    ccs_live_t live = '{input_present: 1'b1, detect_code: 3'h2, charge_phase: 2'h2,
        power_good: 1'b1, thermal_reg: 1'b1, boost_overload: 1'b1, thermal_shutdown: 1'b1,
        battery_overvoltage: 1'b1, thermistor: 3'h3, warm_band: 1'b1, default: 1'b0};
    wire sda = ~(sda_low | (sda_oe & ~sdo) | sda_oe_b);
    always #10 sys_clk_i = ~sys_clk_i;
    ccs_host_model u_host (.sys_clk_i(sys_clk_i), .sda_i(sda), .scl_o(scl), .sda_low_o(sda_low));
    ccs_regs #(.OFF_DELAY_CYCLES(200)) u_ccs_regs (.sys_clk_i(sys_clk_i), .rst_i(rst_i),
        .scl_i(scl), .sda_i(sda), .sda_o(sdo), .sda_oe_o(sda_oe), .select_pin_i(1'b1),
        .live_i(live), .input_voltage_limit_i(4'h6), .battery_mv_i(13'h10CC),
        .safety_tick_i(tick), .safety_tick_o(tick_out), .safety_timer_restart_o(restart),
        .force_source_detect_o(fsd), .battery_switch_on_o(on),
        .battery_switch_reset_enable_o(bre), .warm_voltage_cap_o(wc),
        .input_voltage_limit_mv_o(lim));
    // select-pin variant on the same bus at another address
    ccs_regs #(.USE_SELECT_PIN(1'b1), .DEV_ADDR(7'h2B), .OFF_DELAY_CYCLES(200)) u_ccs_regs_b (
        .sys_clk_i(sys_clk_i), .rst_i(rst_i), .scl_i(scl), .sda_i(sda), .sda_o(),
        .sda_oe_o(sda_oe_b), .select_pin_i(sel), .live_i(live), .input_voltage_limit_i(4'h6),
        .battery_mv_i(13'h10CC), .safety_tick_i(1'b0), .safety_tick_o(),
        .safety_timer_restart_o(), .force_source_detect_o(), .battery_switch_on_o(),
        .battery_switch_reset_enable_o(), .warm_voltage_cap_o(), .input_voltage_limit_mv_o());
    // one-cycle base ticks, two clocks apart
    task automatic ticks(input int n);
        repeat (n) begin
            tick = 1'b1;
            @(negedge sys_clk_i);
            tick = 1'b0;
            @(negedge sys_clk_i);
        end
        @(negedge sys_clk_i);
    endtask : ticks
    // count the one-cycle pulses handed on by the block
    always @(negedge sys_clk_i) begin
        n_tick += tick_out;
        n_restart += restart;
    end
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_tests++;
        if (seen !== exp) begin
            errors++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic report_and_stop();
        $display("errors %0d, comparisons %0d", errors, n_tests);
        if (errors == 0 && n_tests > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : report_and_stop
    // main sequence of register accesses
    initial begin
        repeat (20) @(negedge sys_clk_i);
        rst_i = 1'b0;
        repeat (4) @(negedge sys_clk_i);
        u_host.rd(ADDR_MISC_CTRL, v);
        check(v, MISC_CTRL_RST);
        check({fsd, bre, on, wc}, 4'h7);
        check(lim, 14'h1194);
        ticks(4);
        check(n_tick, 2);
        u_host.wr(ADDR_MISC_CTRL, 8'hB7);
        u_host.rd(ADDR_MISC_CTRL, v);
        check(v, 8'hB7);
        check({fsd, bre, on, wc}, 4'hC);
        check(lim, 14'h11F8);
        ticks(4);
        check(n_tick, 6);
        u_host.wr(ADDR_MISC_CTRL, 8'h4C);
        check(on, 1'b1);
        u_host.wr(ADDR_MISC_CTRL, 8'h6C);
        check(on, 1'b1);
        repeat (200) @(negedge sys_clk_i);
        check(on, 1'b0);
        u_host.rd(ADDR_OP_STATUS, v);
        check(v, 8'h56);
        u_host.rd(ADDR_FAULT_STATUS, v);
        check(v, 8'h6B);
        u_host.wr(ADDR_OP_STATUS, 8'hFF);
        u_host.rd(ADDR_OP_STATUS, v);
        check(v, 8'h56);
        u_host.wr(ADDR_SYS_CTRL, 8'h80);
        u_host.rd(ADDR_SYS_CTRL, v);
        check(v, 8'h00);
        u_host.rd(ADDR_MISC_CTRL, v);
        check(v, MISC_CTRL_RST);
        check(n_restart, 1);
        u_host.wr(ADDR_MISC_CTRL, 8'h97);
        live.watchdog_expired = 1'b1;
        u_host.rd(ADDR_MISC_CTRL, v);
        check(v, 8'h47);
        live.boost_mode = 1'b1;
        u_host.rd(ADDR_FAULT_STATUS, v);
        check(v, 8'hE8);
        u_host.adr = 7'h2B;
        u_host.rd(ADDR_MISC_CTRL, v);
        check(v, 8'hCC);
        sel = 1'b0;
        u_host.rd(ADDR_OP_STATUS, v);
        check(v, 8'h76);
        check(u_host.nak, 0);
        report_and_stop();
    end
    // watchdog cuts a hung run short
    initial begin
        repeat (40000) @(negedge sys_clk_i);
        errors++;
        report_and_stop();
    end
endmodule : tb
